// *** hw/irs_consts.svh ***
`ifndef IRS_CONSTS_SVH
`define IRS_CONSTS_SVH
`define IRS_LEVELS 8
`define IRS_LVL_W 3
`define IRS_ZERO8 8'h00
`define IRS_RST_LVL 3'h7
`define IRS_CALL_OPCODE 8'hCD
`define IRS_W1_TRIG_LEVEL 3
`define IRS_W1_INTERVAL4 2
`define IRS_W1_ADDR_HI 7
`define IRS_W1_ADDR_LO 5
`define IRS_W1_ADDR_MID 6
`define IRS_W2_TYPE_HI 7
`define IRS_W2_TYPE_LO 3
`define IRS_W4_AUTO_EOS 1
`endif

// *** hw/irs_pkg.sv ***
`default_nettype none
package irs_pkg;
  typedef enum logic [2:0] {
    IRS_IDLE,
    IRS_P1_LOW,
    IRS_GAP1,
    IRS_P2_LOW,
    IRS_GAP2,
    IRS_P3_LOW
  } irs_state_e;
endpackage
`default_nettype wire

// *** hw/irs_core.sv ***
`include "irs_consts.svh"
`default_nettype none
// How it works
// - Edge mode: request_in synchronised, rising edge latched into request_latch.
// - Level mode: request_in levels registered straight into request_latch.
// - request_latch frozen from first ack_n fall until the sequence ends.
// - No new interrupt offered until the acknowledge sequence completes.
// - request_latch is eight bits, bit n for request_in line n.
// - service_latch is eight bits; bit enabled by first ack_n pulse.
// - Automatic end-of-service clears in-service bit on final ack_n rise.
// - cpu_request_out raised only for an unmasked request passing priority.
// - Three-byte mode: opcode 11001101 driven while first ack_n low.
// - First ack_n rise sets selected in-service bit, clears its request.
// - Three-byte mode: lower vector byte driven from second ack_n fall.
// - Interval 4: address bits 7..5, level in 4..2, zeros below.
// - Interval 8: address bits 7..6, level in 5..3, zeros below.
// - Vector address bits come from init_word_one bits 7..5 (interval 4) or bits 7..6 (interval 8).
// - Three-byte mode: upper byte is init_word_two, from third ack_n fall.
// - Single-byte mode: nothing driven during first ack_n pulse.
// - Single-byte mode: second pulse drives type bits 7..3, level 2..0.
// - Level 0 is highest priority, level 7 lowest.
// - Automatic end-of-service selected by init_word_four bit 1.
// - Non-specific service_done_cmd clears highest-priority in-service bit.
module irs_core
  import irs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] request_in,
  input wire logic ack_n,
  input wire logic [7:0] init_word_one,
  input wire logic [7:0] init_word_two,
  input wire logic [7:0] init_word_four,
  input wire logic [7:0] mask_bits,
  input wire logic three_byte_mode,
  input wire logic service_done_cmd,
  output logic cpu_request_out,
  output logic [7:0] data_out_bus,
  output logic data_drive_n,
  output logic [7:0] pending_request_bits,
  output logic [7:0] in_service_bits
);

  // ==========================================================
  // Priority helper
  // ==========================================================
  function automatic logic [3:0] first_set(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = `IRS_LEVELS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  // ==========================================================
  // State
  // ==========================================================
  irs_state_e state_q, state_d;
  logic ack_prev_q;
  logic three_q, three_d;
  logic [2:0] sel_q, sel_d;
  logic sel_v_q, sel_v_d;
  logic [7:0] sync1_q, sync2_q, prev_q, hold_q, hold_d;
  logic [7:0] irr_q, irr_d;
  logic [7:0] isr_q, isr_d;
  logic cpu_request_d;
  logic [7:0] data_d;
  logic drive_n_d;

  logic ack_fall, ack_rise, frozen, level_mode, auto_eos, last_rise;
  logic [7:0] edge_hit, cand;
  logic [3:0] cand_top, isr_top;
  logic qualifies;

  // Strobe taken as synchronous, so edges are seen in the first cycle ack_n is sampled at its new level
  assign ack_fall = ack_prev_q & ~ack_n;
  assign ack_rise = ~ack_prev_q & ack_n;
  assign level_mode = init_word_one[`IRS_W1_TRIG_LEVEL];
  assign auto_eos = init_word_four[`IRS_W4_AUTO_EOS];
  assign frozen = (state_q != IRS_IDLE) || ack_fall;
  assign edge_hit = sync2_q & ~prev_q;
  assign cand = irr_q & ~mask_bits;
  assign cand_top = first_set(cand);
  assign isr_top = first_set(isr_q);
  // Equal level loses: a level in service blocks its own repeat
  assign qualifies = cand_top[3] && (!isr_top[3] || cand_top[2:0] < isr_top[2:0]);
  assign last_rise = ack_rise && ((state_q == IRS_P3_LOW) || (state_q == IRS_P2_LOW && !three_q));

  // ==========================================================
  // Acknowledge sequencer
  // ==========================================================
  always_comb begin
    state_d = state_q;
    three_d = three_q;
    sel_d = sel_q;
    sel_v_d = sel_v_q;
    case (state_q)
      IRS_IDLE: begin
        if (ack_fall) begin
          state_d = IRS_P1_LOW;
          three_d = three_byte_mode;
          sel_v_d = qualifies;
          sel_d = qualifies ? cand_top[2:0] : `IRS_RST_LVL;
        end
      end
      IRS_P1_LOW: begin
        if (ack_rise) begin
          state_d = IRS_GAP1;
        end
      end
      IRS_GAP1: begin
        if (ack_fall) begin
          state_d = IRS_P2_LOW;
        end
      end
      IRS_P2_LOW: begin
        if (ack_rise) begin
          state_d = three_q ? IRS_GAP2 : IRS_IDLE;
        end
      end
      IRS_GAP2: begin
        if (ack_fall) begin
          state_d = IRS_P3_LOW;
        end
      end
      IRS_P3_LOW: begin
        if (ack_rise) begin
          state_d = IRS_IDLE;
        end
      end
      default: begin
        state_d = IRS_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Request and in-service latches
  // ==========================================================
  // Edges seen while frozen are parked, not lost, and merge back after the sequence
  assign hold_d = frozen ? (hold_q | (level_mode ? `IRS_ZERO8 : edge_hit)) : `IRS_ZERO8;

  for (genvar n = 0; n < `IRS_LEVELS; n++) begin : g_bit
    always_comb begin
      irr_d[n] = irr_q[n];
      isr_d[n] = isr_q[n];
      if (!frozen) begin
        if (level_mode) begin
          irr_d[n] = request_in[n];
        end else begin
          irr_d[n] = irr_q[n] | edge_hit[n] | hold_q[n];
        end
      end
      if (service_done_cmd && isr_top[3] && isr_top[2:0] == 3'(n)) begin
        isr_d[n] = 1'b0;
      end
      if (last_rise && auto_eos && sel_v_q && sel_q == 3'(n)) begin
        isr_d[n] = 1'b0;
      end
      if (state_q == IRS_P1_LOW && ack_rise && sel_v_q && sel_q == 3'(n)) begin
        isr_d[n] = 1'b1;
        irr_d[n] = 1'b0;
      end
    end
  end

  // ==========================================================
  // Output byte
  // ==========================================================
  always_comb begin
    data_d = `IRS_ZERO8;
    drive_n_d = 1'b1;
    case (state_d)
      IRS_P1_LOW: begin
        if (state_q == IRS_IDLE ? three_byte_mode : three_q) begin
          data_d = `IRS_CALL_OPCODE;
          drive_n_d = 1'b0;
        end
      end
      IRS_P2_LOW: begin
        drive_n_d = 1'b0;
        if (three_q) begin
          if (init_word_one[`IRS_W1_INTERVAL4]) begin
            data_d = {init_word_one[`IRS_W1_ADDR_HI:`IRS_W1_ADDR_LO], sel_q, 2'b00};
          end else begin
            data_d = {init_word_one[`IRS_W1_ADDR_HI:`IRS_W1_ADDR_MID], sel_q, 3'b000};
          end
        end else begin
          data_d = {init_word_two[`IRS_W2_TYPE_HI:`IRS_W2_TYPE_LO], sel_q};
        end
      end
      IRS_P3_LOW: begin
        data_d = init_word_two;
        drive_n_d = 1'b0;
      end
      default: begin
        data_d = `IRS_ZERO8;
        drive_n_d = 1'b1;
      end
    endcase
    cpu_request_d = qualifies && state_q == IRS_IDLE && state_d == IRS_IDLE;
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= IRS_IDLE;
      ack_prev_q <= 1'b1;
      three_q <= 1'b0;
      sel_q <= `IRS_RST_LVL;
      sel_v_q <= 1'b0;
      sync1_q <= `IRS_ZERO8;
      sync2_q <= `IRS_ZERO8;
      prev_q <= `IRS_ZERO8;
      hold_q <= `IRS_ZERO8;
      irr_q <= `IRS_ZERO8;
      isr_q <= `IRS_ZERO8;
      cpu_request_out <= 1'b0;
      data_out_bus <= `IRS_ZERO8;
      data_drive_n <= 1'b1;
      pending_request_bits <= `IRS_ZERO8;
      in_service_bits <= `IRS_ZERO8;
    end else begin
      state_q <= state_d;
      ack_prev_q <= ack_n;
      three_q <= three_d;
      sel_q <= sel_d;
      sel_v_q <= sel_v_d;
      sync1_q <= request_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      hold_q <= hold_d;
      irr_q <= irr_d;
      isr_q <= isr_d;
      cpu_request_out <= cpu_request_d;
      data_out_bus <= data_d;
      data_drive_n <= drive_n_d;
      pending_request_bits <= irr_d;
      in_service_bits <= isr_d;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  // Reset cycles are excluded from every check below
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [2:0] eos_lvl;
  assign eos_lvl = isr_top[2:0];

  chk_opcode_window: assert property (
    state_q == IRS_P1_LOW && three_q |-> !data_drive_n && data_out_bus == `IRS_CALL_OPCODE)
    else $error("opcode missing in first pulse");
  chk_single_quiet: assert property (
    state_q == IRS_P1_LOW && !three_q |-> data_drive_n && data_out_bus == `IRS_ZERO8)
    else $error("data driven in single-byte first pulse");
  chk_latch_frozen: assert property (
    state_q inside {IRS_GAP1, IRS_P2_LOW, IRS_GAP2, IRS_P3_LOW} && $past(state_q) == state_q |-> $stable(irr_q))
    else $error("request latch moved while frozen");
  chk_service_set: assert property (
    state_q == IRS_P1_LOW && ack_rise && sel_v_q |=> isr_q[$past(sel_q)] && !irr_q[$past(sel_q)])
    else $error("first rise did not move request to service");
  chk_auto_clear: assert property (
    last_rise && auto_eos && sel_v_q |=> !isr_q[$past(sel_q)] ##1 state_q == IRS_IDLE || ack_fall)
    else $error("auto end-of-service did not clear");
  chk_busy_quiet: assert property (
    state_q != IRS_IDLE |=> !cpu_request_out)
    else $error("request offered mid-sequence");
  chk_level_load: assert property (
    state_q == IRS_IDLE && ack_n && ack_prev_q && level_mode |=> irr_q == $past(request_in))
    else $error("level mode latch mismatch");
  chk_lower_level: assert property (
    state_q == IRS_P2_LOW && three_q && init_word_one[`IRS_W1_INTERVAL4] |-> data_out_bus[4:2] == sel_q)
    else $error("lower byte level field wrong");
  chk_single_vector: assert property (
    state_q == IRS_P2_LOW && !three_q |-> data_out_bus[2:0] == sel_q && !data_drive_n)
    else $error("single-byte vector wrong");
  chk_eos_clear: assert property (
    service_done_cmd && isr_top[3] && !(state_q == IRS_P1_LOW && ack_rise) |=> !isr_q[$past(eos_lvl)])
    else $error("service done did not clear top bit");
  chk_upper_byte: assert property (
    state_q == IRS_P3_LOW |-> !data_drive_n && data_out_bus == $past(init_word_two))
    else $error("upper vector byte wrong");
  chk_eight_layout: assert property (
    state_q == IRS_P2_LOW && three_q && !$past(init_word_one[`IRS_W1_INTERVAL4])
    |-> data_out_bus[5:0] == {sel_q, 3'b000})
    else $error("lower byte interval-eight layout wrong");
  chk_bus_released: assert property (
    state_q inside {IRS_IDLE, IRS_GAP1, IRS_GAP2} |-> data_drive_n && data_out_bus == `IRS_ZERO8)
    else $error("bus driven outside a byte window");
  chk_edge_latch: assert property (
    state_q == IRS_IDLE && !ack_fall && !level_mode && edge_hit != `IRS_ZERO8
    |=> (irr_q & $past(edge_hit)) == $past(edge_hit))
    else $error("detected edge not latched");
  chk_request_offer: assert property (
    state_q == IRS_IDLE && !ack_fall |=> cpu_request_out == $past(qualifies))
    else $error("request output does not follow qualification");
  chk_service_source: assert property (
    !(state_q == IRS_P1_LOW && ack_rise) |=> (isr_q & ~$past(isr_q)) == `IRS_ZERO8)
    else $error("service bit set outside first pulse");

  cov_three_byte: cover property (state_q == IRS_P3_LOW && ack_rise);
  cov_single_byte: cover property (state_q == IRS_P2_LOW && !three_q && ack_rise);
  cov_service_done: cover property (service_done_cmd && isr_top[3]);
  cov_interval_eight: cover property (state_q == IRS_P2_LOW && three_q && !init_word_one[`IRS_W1_INTERVAL4]);
  cov_edge_parked: cover property (frozen && !level_mode && edge_hit != `IRS_ZERO8);

endmodule
`default_nettype wire

// *** sim/irs_host_model.sv ***
`default_nettype none
module irs_host_model (
  input wire logic clk,
  input wire logic [7:0] data_out_bus,
  input wire logic data_drive_n,
  output logic ack_n,
  output logic service_done_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ack_n = 1'b1;
    service_done_cmd = 1'b0;
  end
  // ==========
  // Acknowledge sequence
  // Low and high phases of 3 cycles each, well above the minimum
  // opcode pulse (three-byte mode only) then vector pulses
  task automatic acknowledge(input int pulses, output logic [23:0] got, output logic [2:0] drv);
    got = 24'h00_0000;
    drv = 3'h7;
    for (int i = 0; i < pulses; i++) begin
      @(posedge clk);
      ack_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      got[8*i+:8] = data_out_bus;
      drv[i] = data_drive_n;
      @(posedge clk);
      ack_n <= 1'b1;
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic end_service();
    @(posedge clk);
    service_done_cmd <= 1'b1;
    @(posedge clk);
    service_done_cmd <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** sim/irs_core_test.sv ***
`default_nettype none
module irs_core_test import irs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] request_in = 8'h00;
  logic [7:0] init_word_one = 8'h00;
  logic [7:0] init_word_two = 8'h00;
  logic [7:0] init_word_four = 8'h00;
  logic [7:0] mask_bits = 8'h00;
  logic three_byte_mode = 1'b1;
  logic ack_n;
  logic service_done_cmd;
  logic cpu_request_out;
  logic [7:0] data_out_bus;
  logic data_drive_n;
  logic [7:0] pending_request_bits;
  logic [7:0] in_service_bits;
  logic [23:0] got;
  logic [2:0] drv;
  int fail_count = 0;
  int checks_done = 0;
  always #25 clk = ~clk;
  irs_core DUT (.clk(clk), .rst(rst), .request_in(request_in), .ack_n(ack_n), .init_word_one(init_word_one),
    .init_word_two(init_word_two), .init_word_four(init_word_four), .mask_bits(mask_bits),
    .three_byte_mode(three_byte_mode), .service_done_cmd(service_done_cmd), .cpu_request_out(cpu_request_out),
    .data_out_bus(data_out_bus), .data_drive_n(data_drive_n), .pending_request_bits(pending_request_bits),
    .in_service_bits(in_service_bits));
  irs_host_model HOST (.clk(clk), .data_out_bus(data_out_bus), .data_drive_n(data_drive_n), .ack_n(ack_n),
    .service_done_cmd(service_done_cmd));
  // ==========
  // Helpers
  task automatic chk(input logic [7:0] act, input logic [7:0] exp);
    checks_done++;
    if (act !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Whole run is under a hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    complete_run();
  end
  // ==========
  // Tests
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    settle(1);
    chk({7'h00, cpu_request_out}, 8'h00);
    chk({7'h00, data_drive_n}, 8'h01);
    chk(pending_request_bits, 8'h00);
    $display("test reset done");
    @(posedge clk);
    init_word_one <= 8'hAC;
    init_word_two <= 8'h5A;
    request_in <= 8'h28;
    settle(4);
    chk(pending_request_bits, 8'h28);
    chk({7'h00, cpu_request_out}, 8'h01);
    HOST.acknowledge(3, got, drv);
    chk(got[7:0], 8'hCD);
    chk(got[15:8], 8'hAC);
    chk(got[23:16], 8'h5A);
    chk({5'h00, drv}, 8'h00);
    settle(2);
    chk(in_service_bits, 8'h08);
    chk({7'h00, cpu_request_out}, 8'h00);
    @(posedge clk);
    request_in <= 8'h20;
    settle(3);
    chk(pending_request_bits, 8'h20);
    chk({7'h00, cpu_request_out}, 8'h00);
    HOST.end_service();
    settle(2);
    chk(in_service_bits, 8'h00);
    chk({7'h00, cpu_request_out}, 8'h01);
    $display("test level three-byte done");
    @(posedge clk);
    three_byte_mode <= 1'b0;
    init_word_four <= 8'h02;
    settle(1);
    HOST.acknowledge(2, got, drv);
    chk({7'h00, drv[0]}, 8'h01);
    chk(got[7:0], 8'h00);
    chk(got[15:8], 8'h5D);
    chk({7'h00, drv[1]}, 8'h00);
    settle(2);
    chk(in_service_bits, 8'h00);
    @(posedge clk);
    request_in <= 8'h00;
    settle(3);
    chk(pending_request_bits, 8'h00);
    $display("test single-byte done");
    @(posedge clk);
    init_word_one <= 8'hC0;
    three_byte_mode <= 1'b1;
    mask_bits <= 8'h40;
    request_in <= 8'h40;
    @(posedge clk);
    request_in <= 8'h00;
    settle(6);
    chk(pending_request_bits, 8'h40);
    chk({7'h00, cpu_request_out}, 8'h00);
    @(posedge clk);
    mask_bits <= 8'h00;
    settle(3);
    chk({7'h00, cpu_request_out}, 8'h01);
    HOST.acknowledge(3, got, drv);
    chk(got[7:0], 8'hCD);
    chk(got[15:8], 8'hF0);
    chk(got[23:16], 8'h5A);
    settle(2);
    chk(pending_request_bits, 8'h00);
    chk(in_service_bits, 8'h00);
    $display("test edge interval-eight done");
    complete_run();
  end
endmodule
`default_nettype wire
